// *** design/txaps_pkg.sv ***
// shared constants for the transmit activity power-state block
package txaps_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  // timing figures in microseconds, slow period in nanoseconds
  localparam int unsigned WAKE_LIMIT_US    = 100;
  localparam int unsigned SHUT_LIMIT_US    = 100;
  localparam int unsigned SETTLE_TIME_US   = 50;
  localparam int unsigned SLOW_PERIOD_NS   = 1000;
  localparam int unsigned TRIG_DELAY_US    = 100;
  // derived cycle counts
  localparam int unsigned WAKE_CYC   = WAKE_LIMIT_US * CLK_MHZ;
  localparam int unsigned SHUT_CYC   = SHUT_LIMIT_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
  localparam int unsigned TRIG_CYC   = TRIG_DELAY_US * CLK_MHZ;
  // edge gap above which input counts as slow (twice the 1000 ns slow period, 2 us)
  localparam int unsigned SLOW_GAP_CYC = 2 * SLOW_PERIOD_NS * CLK_MHZ / 1000;
  // edges needed to call activity valid
  localparam int unsigned WAKE_EDGES = 4;
  localparam int unsigned CNT_W      = 24;
  typedef enum logic [1:0] {
    TXAPS_SETTLE = 2'b00,
    TXAPS_OFF    = 2'b01,
    TXAPS_ON     = 2'b10
  } txaps_state_t;
endpackage

// *** design/txaps_if.sv ***
// link between the upstream controller end and the converter end
`timescale 1ns/10ps
interface txaps_if;
  logic electrical_data_input;
  logic hold_n;
  modport ctrl (output electrical_data_input, output hold_n);
  modport conv (input electrical_data_input, input hold_n);
endinterface

// *** design/txaps_conv.sv ***
// converter end: activity detection and power-state control
`timescale 1ns/10ps
// Notes on behaviour
// R1: static or slow input forces off within limit
// R2: shutdown timed from last falling input edge; the converter times it from the last edge of either polarity
// R3: valid activity brings on-state within wake limit
// R4: wake timed from first rising input edge
// R5: hold low forces and keeps off-state
// R6: hold release with activity wakes within limit
// R7: detection ready after supply settle time
// R8: hold source keeps hold low through settling
// R9: stimulus may trigger capture after wake limit
// R10: stimulus may mark data shutdown limit
// R11: stimulus marks hold shutdown limit
// R12: slow square wave keeps converter off
// R13: off drives nothing, on forwards data
module txaps_conv
  import txaps_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned GAP_CYCLES    = SLOW_GAP_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  txaps_if.conv     link,
  output logic      coax_data_output_o,
  output logic      coax_enable_o,
  output logic      on_state_o
);
  logic             din_s1;
  logic             din_s2;
  logic             din_d;
  logic             hold_s1;
  logic             hold_s2;
  logic [CNT_W-1:0] gap_cnt;
  logic [CNT_W-1:0] settle_cnt;
  logic [2:0]       edge_cnt;
  txaps_state_t     state;
  logic             rise;
  logic             fall;
  logic             slow;
  logic             wake_q;
  logic             shut_q;
  logic             on_now;

  // data pin synchroniser
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      din_s1 <= link.electrical_data_input;
      din_s2 <= din_s1;
    end
  end

  // hold pin synchroniser
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end else begin
      hold_s1 <= link.hold_n;
      hold_s2 <= hold_s1;
    end
  end

  // last level, reset to idle low so no false edge follows reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      din_d <= 1'b0;
    end else begin
      din_d <= din_s2;
    end
  end

  assign rise   = din_s2 & ~din_d;
  assign fall   = ~din_s2 & din_d;
  assign slow   = (gap_cnt >= CNT_W'(GAP_CYCLES));
  assign on_now = (state == TXAPS_ON);

  // gap since last edge; a fall restarts shutdown timing (see R2)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_cnt <= CNT_W'(GAP_CYCLES);
    end else if (rise || fall) begin
      gap_cnt <= '0;
    end else if (!slow) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  // count fast edges from first rise; slow gaps reset it (see R4) (see R12)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_cnt <= '0;
    end else if (state == TXAPS_SETTLE) begin
      edge_cnt <= '0; // see R7
    end else if (slow && !rise) begin
      edge_cnt <= '0;
    end else if (rise && edge_cnt != 3'(WAKE_EDGES)) begin
      edge_cnt <= edge_cnt + 1'b1;
    end
  end

  // supply settle timer (see R7)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_cnt <= '0;
    end else if (state == TXAPS_SETTLE) begin
      settle_cnt <= settle_cnt + 1'b1;
    end
  end

  // wake request; a slow gap vetoes a stale full edge count (see R3) (see R6)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= hold_s2 && (edge_cnt == 3'(WAKE_EDGES)) && !slow;
    end
  end

  // shutdown request on hold low or quiet input (see R1) (see R5)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= !hold_s2 || slow;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= TXAPS_SETTLE;
    end else begin
      case (state)
        TXAPS_SETTLE: begin
          if (settle_cnt >= CNT_W'(SETTLE_CYCLES) - 1'b1) begin
            state <= TXAPS_OFF; // see R7
          end
        end
        TXAPS_OFF: begin
          if (wake_q) begin
            state <= TXAPS_ON; // see R3 see R6
          end
        end
        TXAPS_ON: begin
          if (shut_q) begin
            state <= TXAPS_OFF; // see R1 see R5
          end
        end
        default: state <= TXAPS_OFF;
      endcase
    end
  end

  // output gating (see R13)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      coax_data_output_o <= 1'b0;
    end else begin
      coax_data_output_o <= on_now & din_s2;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      coax_enable_o <= 1'b0;
    end else begin
      coax_enable_o <= on_now;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      on_state_o <= 1'b0;
    end else begin
      on_state_o <= on_now;
    end
  end
endmodule

// *** design/txaps_ctrl.sv ***
// controller end: drives data and hold, emits markers
`timescale 1ns/10ps
module txaps_ctrl
  import txaps_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned SHUT_CYCLES = SHUT_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic data_i,
  input  wire logic hold_req_n_i,
  input  wire logic data_stop_i,
  txaps_if.ctrl     link,
  output logic      wake_mark_o,
  output logic      shut_mark_o
);
  logic             data_q;
  logic             hold_q;
  logic             ready;
  logic [CNT_W-1:0] settle_cnt;
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] shut_cnt;
  logic             hold_prev;
  logic             stop_prev;

  assign link.electrical_data_input = data_q;
  assign link.hold_n                = hold_q;

  // hold kept low until settle elapsed (see R8)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_cnt <= '0;
      ready      <= 1'b0;
    end else if (!ready) begin
      settle_cnt <= settle_cnt + 1'b1;
      ready      <= (settle_cnt >= CNT_W'(SETTLE_CYCLES) - 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_q    <= 1'b0;
      hold_q    <= 1'b0;
      hold_prev <= 1'b0;
      stop_prev <= 1'b0;
    end else begin
      data_q    <= data_i;
      hold_q    <= ready & hold_req_n_i;
      hold_prev <= hold_q;
      stop_prev <= data_stop_i;
    end
  end

  // wake marker one limit after hold release (see R9)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_cnt    <= '0;
      wake_mark_o <= 1'b0;
    end else begin
      wake_mark_o <= (wake_cnt == CNT_W'(1));
      if (hold_q && !hold_prev) begin
        wake_cnt <= CNT_W'(WAKE_CYCLES);
      end else if (wake_cnt != '0) begin
        wake_cnt <= wake_cnt - 1'b1;
      end
    end
  end

  // shutdown marker after hold fall or data stop (see R10) (see R11)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shut_cnt    <= '0;
      shut_mark_o <= 1'b0;
    end else begin
      shut_mark_o <= (shut_cnt == CNT_W'(1));
      if ((!hold_q && hold_prev) || (data_stop_i && !stop_prev)) begin
        shut_cnt <= CNT_W'(SHUT_CYCLES);
      end else if (shut_cnt != '0) begin
        shut_cnt <= shut_cnt - 1'b1;
      end
    end
  end
endmodule

// *** dv/txaps_properties.sv ***
// assertions on the controller-to-converter link
`timescale 1ns/10ps
module txaps_properties #(
  parameter int SHUT_B   = 100,
  parameter int WAKE_B   = 100,
  parameter int GAP_C    = 50,
  parameter int SETTLE_C = 20
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic electrical_data_input,
  input wire logic hold_n,
  input wire logic coax_data_output_o,
  input wire logic coax_enable_o,
  input wire logic on_state_o,
  input wire logic shut_mark_o
);
  localparam int SM_LO = SHUT_B - 2;
  localparam int SM_HI = SHUT_B + 2;
  logic        d_q;
  logic [15:0] q, s, a;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // quiet time, time since reset, active time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      d_q <= 1'b0;
      q   <= 16'h0000;
      s   <= 16'h0000;
    end else begin
      d_q <= electrical_data_input;
      q   <= (electrical_data_input != d_q) ? 16'h0000 : q + {15'h0000, q != 16'hffff};
      s   <= s + {15'h0000, s != 16'hffff};
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a <= 16'h0000;
    end else if (q >= GAP_C / 2 || !hold_n || s < SETTLE_C) begin
      a <= 16'h0000;
    end else begin
      a <= a + {15'h0000, a != 16'hffff};
    end
  end
  a_off_output_quiet: assert property (!on_state_o && !$past(on_state_o) |->
    !coax_enable_o && !coax_data_output_o) else $error("output active while off");
  a_on_output_enabled: assert property (on_state_o && $past(on_state_o) |-> coax_enable_o)
    else $error("output disabled while on");
  a_on_data_forward: assert property (on_state_o |->
    coax_data_output_o == $past(electrical_data_input, 3)) else $error("data not forwarded");
  a_hold_forces_off: assert property ((!hold_n) [*8] |-> !on_state_o)
    else $error("on while hold low");
  a_quiet_shuts_down: assert property (q >= SHUT_B |-> !on_state_o)
    else $error("on after quiet input");
  a_wake_in_time: assert property (a >= WAKE_B |-> on_state_o)
    else $error("no wake within limit");
  a_settle_stays_off: assert property (s < SETTLE_C |-> !on_state_o)
    else $error("on during settle");
  a_settle_hold_low: assert property (s < SETTLE_C - 2 |-> !hold_n)
    else $error("hold released during settle");
  a_hold_shut_mark: assert property ($fell(hold_n) |-> ##[SM_LO:SM_HI] shut_mark_o)
    else $error("shutdown marker missing");
  a_mark_one_cycle: assert property (shut_mark_o |=> !shut_mark_o)
    else $error("marker too long");
  c_wake: cover property ($rose(on_state_o));
  c_shut: cover property ($fell(on_state_o));
  c_mark: cover property (shut_mark_o);
endmodule

// *** dv/txaps_tb.sv ***
// self-checking bench for both ends of the power-state link
`timescale 1ns/10ps
module txaps_tb;
  logic clk_i, nrst_i, data_i, hold_req_n_i, data_stop_i, run;
  logic coax_data_output_o, coax_enable_o, on_state_o, wake_mark_o, shut_mark_o;
  int   bad_count, check_count, cnt, hp, wm_n, sm_n, w0;
  txaps_if link ();
  txaps_ctrl #(.WAKE_CYCLES(100), .SHUT_CYCLES(100), .SETTLE_CYCLES(20)) txaps_ctrl_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .data_i(data_i), .hold_req_n_i(hold_req_n_i),
    .data_stop_i(data_stop_i), .link(link), .wake_mark_o(wake_mark_o), .shut_mark_o(shut_mark_o));
  txaps_conv #(.SETTLE_CYCLES(20), .GAP_CYCLES(50)) txaps_conv_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .link(link), .coax_data_output_o(coax_data_output_o), .coax_enable_o(coax_enable_o),
    .on_state_o(on_state_o));
  txaps_properties txaps_properties_i (.clk_i(clk_i), .nrst_i(nrst_i), .hold_n(link.hold_n),
    .electrical_data_input(link.electrical_data_input), .coax_data_output_o(coax_data_output_o),
    .coax_enable_o(coax_enable_o), .on_state_o(on_state_o), .shut_mark_o(shut_mark_o));
  always #2.5 clk_i = ~clk_i;
  // square wave source, half period hp+1 cycles
  always @(posedge clk_i) begin
    cnt  <= (cnt >= hp) ? 0 : cnt + 1;
    data_i <= (cnt >= hp) ? (run & ~data_i) : data_i;
    wm_n <= wm_n + int'(wake_mark_o);
    sm_n <= sm_n + int'(shut_mark_o);
  end
  task w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    w(3000);
    bad_count++;
    end_sim;
  end
  initial begin
    {clk_i, nrst_i, data_i, data_stop_i, run} = 5'h00;
    hold_req_n_i = 1'b1;
    hp = 3;
    w(8);
    @(posedge clk_i) nrst_i <= 1'b1;
    w(10);
    chk(link.hold_n, 1'b0);
    chk(on_state_o, 1'b0);
    @(posedge clk_i) run <= 1'b1;
    w(110);
    chk(on_state_o, 1'b1);
    chk(coax_enable_o, 1'b1);
    @(posedge clk_i) hp <= 60;
    w(300);
    chk(on_state_o, 1'b0);
    chk(coax_enable_o, 1'b0);
    chk(coax_data_output_o, 1'b0);
    @(posedge clk_i) hp <= 3;
    w(110);
    chk(on_state_o, 1'b1);
    @(posedge clk_i) data_stop_i <= 1'b1;
    run <= 1'b0;
    w(110);
    chk(on_state_o, 1'b0);
    chk(sm_n, 1);
    @(posedge clk_i) data_stop_i <= 1'b0;
    run <= 1'b1;
    w(110);
    @(posedge clk_i) hold_req_n_i <= 1'b0;
    w(110);
    chk(sm_n, 2);
    w(200);
    chk(on_state_o, 1'b0);
    chk(coax_data_output_o, 1'b0);
    w0 = wm_n;
    @(posedge clk_i) hold_req_n_i <= 1'b1;
    w(110);
    chk(on_state_o, 1'b1);
    chk(wm_n, w0 + 1);
    end_sim;
  end
endmodule
